// file: src/sas_pkg.sv
// sas_pkg: constants shared by the converter sequencer
// assumes a 25 MHz system clock; one state is one clock cycle
package sas_pkg;
	localparam int RES_W = 10;
	localparam int CH_W = 4;
	localparam int NUM_CH = 16;
	// start delay states per clock-select code (fixed choice inside range)
	localparam logic [9:0] DLY_00 = 10'h012;
	localparam logic [9:0] DLY_01 = 10'h00A;
	localparam logic [9:0] DLY_10 = 10'h006;
	localparam logic [9:0] DLY_11 = 10'h004;
	// sampling states
	localparam logic [9:0] SPL_00 = 10'h07F;
	localparam logic [9:0] SPL_01 = 10'h03F;
	localparam logic [9:0] SPL_10 = 10'h01F;
	localparam logic [9:0] SPL_11 = 10'h00F;
	// first conversion total states (minimum of range)
	localparam logic [9:0] TOT_00 = 10'h203;
	localparam logic [9:0] TOT_01 = 10'h103;
	localparam logic [9:0] TOT_10 = 10'h083;
	localparam logic [9:0] TOT_11 = 10'h043;
	// later scan conversions, fixed
	localparam logic [9:0] SCN_00 = 10'h200;
	localparam logic [9:0] SCN_01 = 10'h100;
	localparam logic [9:0] SCN_10 = 10'h080;
	localparam logic [9:0] SCN_11 = 10'h040;
	localparam logic [1:0] TRG_SW = 2'h0;
	localparam logic [1:0] TRG_TPU = 2'h1;
	localparam logic [1:0] TRG_TMR8 = 2'h2;
	localparam logic [1:0] TRG_PIN = 2'h3;
	localparam logic [9:0] RES_RST = 10'h000;
	typedef enum logic [2:0] {
		SAS_WAIT = 3'b000,
		SAS_DELAY = 3'b001,
		SAS_SAMPLE = 3'b010,
		SAS_CONV = 3'b011
	} sas_state_t;
endpackage

// file: src/sas_sequencer.sv
// sas_sequencer: control sequencer of a 10-bit successive-approximation
// converter with single and scan modes.
// assumes a comparator output from the analog front end, one clk domain,
// external trigger pin asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R01 - each result is a 10-bit successive approximation value
// R02 - software clears start before changing mode or channel
// R03 - single mode converts one selected channel when start becomes 1
// R04 - single result goes to that channel's result register
// R05 - single completion sets end flag; interrupt if enabled
// R06 - start stays 1 during single conversion, auto-cleared at end
// R07 - clearing start mid single conversion aborts to wait
// R08 - scan starts at group base chosen by channel bits 3:2
// R09 - scan stores each result then moves to next channel
// R10 - scan pass end sets flag, interrupts if enabled, restarts group
// R11 - scan repeats while start is 1, stops when cleared
// R12 - start delay, then sample, then convert
// R13 - start delay 18-33, 10-17, 6-9, 4-5 states by clock code
// R14 - sampling 127/63/31/15; totals 515-530 down to 67-68 states
// R15 - later scan conversions take 512/256/128/64 states
// R16 - pin falling edge with trigger code 11 sets start
// R17 - interrupt asserted only while flag and enable both 1; here irq uses the enable of the cycle before, so it lags enable by one cycle
// R18 - end interrupt can activate the transfer controller
// R19 - module stop after reset; registers reachable only when cleared
// R20 - channel field: single direct; scan base plus last channel
// R21 - trigger select: software, timer unit, 8-bit timer, pin
// R22 - mode bit 0 single, 1 scan
// R23 - standby, module stop or reset clears start and halts scan
// R24 - result registers hold last value, readable any time
module sas_sequencer #(
	parameter int RES_W = sas_pkg::RES_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic module_stop,
	input wire logic standby,
	input wire logic sw_start_set,
	input wire logic sw_start_clr,
	input wire logic scan_mode,
	input wire logic [3:0] chan_sel,
	input wire logic [1:0] conv_clk_sel,
	input wire logic [1:0] trig_src_sel,
	input wire logic conv_end_irq_enable,
	input wire logic conv_end_flag_clr,
	input wire logic timer_pulse_unit_trig,
	input wire logic timer8_trig,
	input wire logic ext_trigger_pin_b,
	input wire logic cmp_above,
	input wire logic [3:0] rd_chan,
	output logic conv_start_bit,
	output logic conv_end_flag,
	output logic conv_end_irq,
	output logic data_transfer_ctrl_req,
	output logic sample_hold,
	output logic [3:0] ana_chan,
	output logic [RES_W-1:0] dac_code,
	output logic [RES_W-1:0] rd_data,
	output logic busy
);
	typedef struct packed {
		sas_pkg::sas_state_t st;
		logic start;
		logic flag;
		logic irq;
		logic data_transfer_ctrl;
		logic sh;
		logic [3:0] ch;
		logic [9:0] cnt;
		logic first;
		logic [RES_W-1:0] sar;
		logic [3:0] bitn;
		logic [1:0] pin_s;
		logic pin_prev;
		logic [RES_W-1:0] rd;
		logic busy;
	} sas_reg_t;

	sas_reg_t q;
	sas_reg_t d;
	logic [RES_W-1:0] res_q [0:sas_pkg::NUM_CH-1];
	logic wr_en;

	function automatic logic [9:0] dly_of(input logic [1:0] c); // R13
		case (c)
			2'h0: dly_of = sas_pkg::DLY_00;
			2'h1: dly_of = sas_pkg::DLY_01;
			2'h2: dly_of = sas_pkg::DLY_10;
			default: dly_of = sas_pkg::DLY_11;
		endcase
	endfunction

	function automatic logic [9:0] spl_of(input logic [1:0] c); // R14
		case (c)
			2'h0: spl_of = sas_pkg::SPL_00;
			2'h1: spl_of = sas_pkg::SPL_01;
			2'h2: spl_of = sas_pkg::SPL_10;
			default: spl_of = sas_pkg::SPL_11;
		endcase
	endfunction

	// states spent in approximation after delay and sampling
	function automatic logic [9:0] cnv_of(input logic [1:0] c,
		input logic first);
		logic [9:0] tot;
		tot = sas_pkg::TOT_11;
		case (c)
			2'h0: tot = first ? sas_pkg::TOT_00 : sas_pkg::SCN_00;
			2'h1: tot = first ? sas_pkg::TOT_01 : sas_pkg::SCN_01;
			2'h2: tot = first ? sas_pkg::TOT_10 : sas_pkg::SCN_10;
			default: tot = first ? sas_pkg::TOT_11 : sas_pkg::SCN_11;
		endcase
		if (first) begin
			cnv_of = tot - dly_of(c) - spl_of(c); // R14
		end else begin
			cnv_of = tot - spl_of(c); // R15
		end
	endfunction

	// first channel of the conversion run
	function automatic logic [3:0] first_ch(input logic scan,
		input logic [3:0] sel);
		first_ch = scan ? {sel[3:2], 2'h0} : sel; // R08 R20 R22
	endfunction

	logic trig_hit;
	logic conv_done;
	logic last_ch;
	logic [9:0] step_len;
	logic [9:0] cnv_len;
	logic [9:0] first_len;

	always_comb begin
		d = q;
		wr_en = 1'b0;
		d.pin_s = {q.pin_s[0], ext_trigger_pin_b};
		d.pin_prev = q.pin_s[1];
		d.data_transfer_ctrl = 1'b0;
		// start sources
		case (trig_src_sel) // R21
			sas_pkg::TRG_TPU: trig_hit = timer_pulse_unit_trig;
			sas_pkg::TRG_TMR8: trig_hit = timer8_trig;
			sas_pkg::TRG_PIN: trig_hit = q.pin_prev & ~q.pin_s[1]; // R16
			default: trig_hit = 1'b0;
		endcase
		cnv_len = cnv_of(conv_clk_sel, q.first);
		step_len = cnv_len / 10'(RES_W);
		// division remainder goes to the msb step so totals stay exact
		first_len = cnv_len - 10'(step_len * 10'(RES_W - 1)); // R14 R15
		conv_done = 1'b0;
		last_ch = (q.ch[1:0] == chan_sel[1:0]); // R20
		if (sw_start_set || trig_hit) begin
			d.start = 1'b1;
		end
		if (sw_start_clr) begin
			d.start = 1'b0;
		end
		case (q.st)
			sas_pkg::SAS_WAIT: begin
				d.sh = 1'b0;
				if (q.start) begin // R03
					d.st = sas_pkg::SAS_DELAY;
					d.ch = first_ch(scan_mode, chan_sel);
					d.first = 1'b1;
					d.cnt = dly_of(conv_clk_sel) - 10'h001; // R12 R13
				end
			end
			sas_pkg::SAS_DELAY: begin
				if (q.cnt == 10'h000) begin
					d.st = sas_pkg::SAS_SAMPLE; // R12
					d.sh = 1'b1;
					d.cnt = spl_of(conv_clk_sel) - 10'h001;
				end else begin
					d.cnt = q.cnt - 10'h001;
				end
			end
			sas_pkg::SAS_SAMPLE: begin
				if (q.cnt == 10'h000) begin
					d.st = sas_pkg::SAS_CONV;
					d.sh = 1'b0;
					d.sar = {1'b1, {(RES_W-1){1'b0}}};
					d.bitn = 4'(RES_W - 1);
					d.cnt = first_len - 10'h001;
				end else begin
					d.cnt = q.cnt - 10'h001;
				end
			end
			sas_pkg::SAS_CONV: begin
				if (q.cnt != 10'h000) begin
					d.cnt = q.cnt - 10'h001;
				end else begin
					// R01 decide one bit per step, msb first
					if (!cmp_above) begin
						d.sar[q.bitn] = 1'b0;
					end
					if (q.bitn != 4'h0) begin
						d.sar[q.bitn - 4'h1] = 1'b1;
						d.bitn = q.bitn - 4'h1;
						d.cnt = step_len - 10'h001;
					end else begin
						conv_done = 1'b1;
						wr_en = 1'b1; // R04 R09
						d.first = 1'b0;
						if (!scan_mode) begin
							d.start = 1'b0; // R06
							d.flag = 1'b1; // R05
							d.st = sas_pkg::SAS_WAIT;
						end else begin
							if (last_ch) begin
								d.flag = 1'b1; // R10
								d.ch = first_ch(1'b1, chan_sel);
							end else begin
								d.ch = q.ch + 4'h1; // R09
							end
							d.st = sas_pkg::SAS_SAMPLE;
							d.sh = 1'b1;
							d.cnt = spl_of(conv_clk_sel) - 10'h001; // R15
						end
					end
				end
			end
			default: d.st = sas_pkg::SAS_WAIT;
		endcase
		// flag clear loses to a completion in the same cycle
		if (conv_end_flag_clr && !(conv_done && (!scan_mode || last_ch))) begin
			d.flag = 1'b0;
		end
		// clearing start aborts either mode
		if (q.st != sas_pkg::SAS_WAIT && !q.start) begin
			d.st = sas_pkg::SAS_WAIT; // R07 R11
			d.sh = 1'b0;
		end
		if (standby || module_stop) begin
			d.start = 1'b0; // R23 R19
			d.st = sas_pkg::SAS_WAIT;
			d.sh = 1'b0;
		end
		d.irq = d.flag & conv_end_irq_enable; // R17
		d.data_transfer_ctrl = conv_done & (!scan_mode | last_ch) & conv_end_irq_enable; // R18
		d.busy = (d.st != sas_pkg::SAS_WAIT);
		d.rd = module_stop ? sas_pkg::RES_RST : res_q[rd_chan]; // R19 R24
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.st <= sas_pkg::SAS_WAIT;
			q.pin_s <= 2'h3;
			q.pin_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// results hold until overwritten by the same channel
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < sas_pkg::NUM_CH; i++) begin
				res_q[i] <= sas_pkg::RES_RST;
			end
		end else if (wr_en) begin
			res_q[q.ch] <= {q.sar[RES_W-1:1], q.sar[0] & cmp_above}; // R24
		end
	end

	assign conv_start_bit = q.start;
	assign conv_end_flag = q.flag;
	assign conv_end_irq = q.irq;
	assign data_transfer_ctrl_req = q.data_transfer_ctrl;
	assign sample_hold = q.sh;
	assign ana_chan = q.ch;
	assign dac_code = q.sar;
	assign rd_data = q.rd;
	assign busy = q.busy;
endmodule // sas_sequencer
`default_nettype wire

// file: sim/sas_analog_model.sv
// sas_analog_model: sixteen analog input levels behind an ideal comparator
// assumes the bench loads lvl before any conversion starts
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
	input wire logic [3:0] ana_chan,
	input wire logic [9:0] dac_code,
	output logic cmp_above
);
	logic [9:0] lvl [16];
	assign cmp_above = lvl[ana_chan] >= dac_code;
endmodule // sas_analog_model
`default_nettype wire

// file: sim/sas_sequencer_sva.sv
// sas_sequencer_sva: port-level checker for the converter sequencer
// assumes one clk domain and the async active-low rst_b
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic module_stop,
	input wire logic standby,
	input wire logic sw_start_set,
	input wire logic sw_start_clr,
	input wire logic scan_mode,
	input wire logic [3:0] chan_sel,
	input wire logic [1:0] conv_clk_sel,
	input wire logic conv_end_irq_enable,
	input wire logic conv_start_bit,
	input wire logic conv_end_flag,
	input wire logic conv_end_irq,
	input wire logic data_transfer_ctrl_req,
	input wire logic sample_hold,
	input wire logic [3:0] ana_chan,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_irq_lag: assert property (conv_end_irq ==
		(conv_end_flag && $past(conv_end_irq_enable))) else $error("irq");
	chk_stop_clear: assert property (module_stop || standby
		|=> !conv_start_bit) else $error("stop");
	chk_clr_abort: assert property (sw_start_clr
		|=> !conv_start_bit) else $error("abort");
	chk_start_set: assert property (sw_start_set && !sw_start_clr &&
		!module_stop && !standby && !conv_start_bit |=> conv_start_bit)
		else $error("set");
	chk_auto_end: assert property ($fell(conv_start_bit) && !scan_mode
		&& !$past(sw_start_clr) && !$past(module_stop) && !$past(standby)
		|-> conv_end_flag) else $error("end");
	chk_delay_first: assert property ($rose(sample_hold)
		|-> $past(busy, 3)) else $error("delay");
	chk_sample_len: assert property ($rose(sample_hold) &&
		!scan_mode && conv_clk_sel == 2'h3 |-> sample_hold[*8] ##1
		sample_hold[*7] ##1 !sample_hold) else $error("sample");
	chk_chan_map: assert property ($rose(sample_hold) |-> (scan_mode ?
		ana_chan[3:2] == chan_sel[3:2] && ana_chan[1:0] <= chan_sel[1:0]
		: ana_chan == chan_sel)) else $error("chan");
	chk_dtc_pulse: assert property (data_transfer_ctrl_req |->
		conv_end_flag && conv_end_irq_enable ##1 !data_transfer_ctrl_req)
		else $error("dtc");
	cover property ($rose(conv_end_flag) && scan_mode);
	cover property ($fell(conv_start_bit) && !scan_mode);
	cover property (data_transfer_ctrl_req);
endmodule // sas_sequencer_sva
bind sas_sequencer sas_sequencer_sva u_chk (.clk, .rst_b, .module_stop,
	.standby, .sw_start_set, .sw_start_clr, .scan_mode, .chan_sel,
	.conv_clk_sel, .conv_end_irq_enable, .conv_start_bit, .conv_end_flag,
	.conv_end_irq, .data_transfer_ctrl_req, .sample_hold, .ana_chan, .busy);
`default_nettype wire

// file: sim/sas_sequencer_tb_top.sv
// sas_sequencer_tb_top: self-checking bench for the converter sequencer
// assumes sas_analog_model as far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module sas_sequencer_tb_top;
	logic clk = 0, rst_b = 0, module_stop = 0, standby = 0;
	logic sw_start_set = 0, sw_start_clr = 0, scan_mode = 0;
	logic conv_end_irq_enable = 1, conv_end_flag_clr = 0;
	logic timer_pulse_unit_trig = 0, timer8_trig = 0, ext_trigger_pin_b = 1;
	logic [3:0] chan_sel = 0, rd_chan = 0;
	logic [1:0] conv_clk_sel = 0, trig_src_sel = 0;
	wire logic cmp_above, conv_start_bit, conv_end_flag, conv_end_irq;
	wire logic data_transfer_ctrl_req, sample_hold, busy;
	wire logic [3:0] ana_chan;
	wire logic [9:0] dac_code, rd_data;
	int errors = 0, n_compared = 0, seed = 31, cyc = 0, n;
	int tmin[4] = '{515, 259, 131, 67};
	int tmax[4] = '{530, 266, 134, 68};
	sas_sequencer dut (.clk, .rst_b, .module_stop, .standby, .sw_start_set,
		.sw_start_clr, .scan_mode, .chan_sel, .conv_clk_sel, .trig_src_sel,
		.conv_end_irq_enable, .conv_end_flag_clr, .timer_pulse_unit_trig,
		.timer8_trig, .ext_trigger_pin_b, .cmp_above, .rd_chan,
		.conv_start_bit, .conv_end_flag, .conv_end_irq,
		.data_transfer_ctrl_req, .sample_hold, .ana_chan, .dac_code,
		.rd_data, .busy);
	sas_analog_model m (.ana_chan, .dac_code, .cmp_above);
	always #20 clk = ~clk;
	task automatic tick(int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task automatic wait_flag();
		n = 0;
		while (conv_end_flag !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
	endtask
	task automatic chk_res(logic [3:0] ch);
		rd_chan = ch;
		tick(2);
		`CHK("result", m.lvl[ch], rd_data)
	endtask
	function automatic logic in_rng(int v, int lo, int hi);
		return v >= lo && v <= hi;
	endfunction
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		for (int i = 0; i < 16; i++) m.lvl[i] = 10'($random(seed));
		tick(3);
		rst_b = 1;
		`CHK("start_rst", 1'b0, conv_start_bit)
		for (int k = 0; k < 4; k++) begin
			conv_clk_sel = 2'(k);
			chan_sel = 4'($random(seed));
			pulse(sw_start_set);
			wait_flag();
			`CHK("t_conv", 1'b1, in_rng(n, tmin[k] - 2, tmax[k] + 2))
			`CHK("dtc", 1'b1, data_transfer_ctrl_req)
			`CHK("start_end", 1'b0, conv_start_bit)
			tick(1);
			`CHK("irq", 1'b1, conv_end_irq)
			chk_res(chan_sel);
			pulse(conv_end_flag_clr);
			tick(1);
			`CHK("irq_clr", 1'b0, conv_end_irq)
		end
		conv_clk_sel = 2'h0;
		pulse(sw_start_set);
		tick(60);
		pulse(sw_start_clr);
		tick(2);
		`CHK("abort_busy", 1'b0, busy)
		`CHK("abort_flag", 1'b0, conv_end_flag)
		pulse(sw_start_set);
		tick(40);
		module_stop = 1;
		tick(2);
		`CHK("stop_start", 1'b0, conv_start_bit)
		`CHK("stop_rd", 10'h000, rd_data)
		module_stop = 0;
		conv_clk_sel = 2'h3;
		conv_end_irq_enable = 0;
		for (int t = 0; t < 4; t++) begin
			trig_src_sel = 2'(t);
			timer_pulse_unit_trig = 1;
			timer8_trig = 1;
			ext_trigger_pin_b = 0;
			tick(1);
			timer_pulse_unit_trig = 0;
			timer8_trig = 0;
			tick(6);
			ext_trigger_pin_b = 1;
			`CHK("trig", t != 0, conv_start_bit)
			if (t != 0) begin
				wait_flag();
				tick(1);
				`CHK("irq_off", 1'b0, conv_end_irq)
				pulse(conv_end_flag_clr);
			end
		end
		conv_end_irq_enable = 1;
		trig_src_sel = 2'h0;
		scan_mode = 1;
		chan_sel = 4'hE;
		pulse(sw_start_set);
		wait_flag();
		m.lvl[13] = 10'($random(seed));
		pulse(conv_end_flag_clr);
		wait_flag();
		`CHK("t_scan", 1'b1, in_rng(n, 189, 193))
		`CHK("scan_run", 1'b1, conv_start_bit)
		for (int c = 12; c < 15; c++) chk_res(4'(c));
		standby = 1;
		tick(2);
		`CHK("stby", 1'b0, conv_start_bit)
		standby = 0;
		tally_and_finish();
	end
endmodule // sas_sequencer_tb_top
`default_nettype wire
